// ### pkg/buck_b_pkg.sv
package buck_b_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int SETPOINT_W = 6;
    localparam int SETPOINT_CNT = 3;

    // Register byte addresses
    localparam logic [7:0] NORMAL_VOLTAGE_OFS = 8'h43;
    localparam logic [7:0] STANDBY_VOLTAGE_OFS = 8'h44;
    localparam logic [7:0] SLEEP_VOLTAGE_OFS = 8'h45;
    localparam logic [7:0] SWITCHING_MODE_OFS = 8'h46;
    localparam logic [7:0] CONVERTER_CONFIG_OFS = 8'h47;

    // Field positions
    localparam int SETPOINT_LSB = 0;
    localparam int RANGE_BIT = 6;
    localparam int MODE_LSB = 0;
    localparam int MODE_W = 4;
    localparam int SLEEP_BEH_BIT = 5;
    localparam int ILIM_BIT = 0;
    localparam int FREQ_LSB = 2;
    localparam int PHASE_LSB = 4;
    localparam int SPEED_LSB = 6;
    localparam int SEL2_W = 2;

    // Values after reset
    localparam logic [5:0] SETPOINT_RST = 6'h00;
    localparam logic RANGE_RST = 1'b0;
    localparam logic [3:0] MODE_RST = 4'h8;
    localparam logic SLEEP_BEH_RST = 1'b0;
    localparam logic ILIM_RST = 1'b0;
    localparam logic [1:0] SEL2_RST = 2'h0;
    localparam logic [7:0] RD_DATA_RST = 8'h00;

    // Set point table index per operating mode
    localparam logic [1:0] IDX_NORMAL = 2'h0;
    localparam logic [1:0] IDX_STANDBY = 2'h1;
    localparam logic [1:0] IDX_SLEEP = 2'h2;

    // Sleep behaviour encoding
    localparam logic SLEEP_BEH_OFF = 1'b0;
    localparam logic SLEEP_BEH_PFM = 1'b1;

    // Operating mode of the converter, Gray coded
    typedef enum logic [1:0] {
        PWR_NORMAL = 2'b00,
        PWR_STANDBY = 2'b01,
        PWR_SLEEP = 2'b11
    } pwr_state_t;

endpackage

// ### pkg/setpoint_sel_if.sv
`timescale 1ns/1ps
interface setpoint_sel_if;
    import buck_b_pkg::*;
    logic [SETPOINT_W-1:0] setpoint [SETPOINT_CNT];
    logic range_sel;
    logic sleep_behaviour_sel;
    pwr_state_t pwr_state;
    logic [SETPOINT_W-1:0] active_setpoint;
    logic active_range;
    logic converter_on;
    logic pfm_forced;

    modport bank (
        output setpoint,
        output range_sel,
        output sleep_behaviour_sel,
        output pwr_state,
        input active_setpoint,
        input active_range,
        input converter_on,
        input pfm_forced
    );

    modport selector (
        input setpoint,
        input range_sel,
        input sleep_behaviour_sel,
        input pwr_state,
        output active_setpoint,
        output active_range,
        output converter_on,
        output pfm_forced
    );
endinterface

// ### design/setpoint_selector.sv
`timescale 1ns/1ps
module setpoint_selector (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // Bank side
    setpoint_sel_if.selector sel
);
    import buck_b_pkg::*;

    logic [SETPOINT_W-1:0] active_setpoint_ff;
    logic [SETPOINT_W-1:0] nxt_active_setpoint;
    logic active_range_ff;
    logic nxt_active_range;
    logic converter_on_ff;
    logic nxt_converter_on;
    logic pfm_forced_ff;
    logic nxt_pfm_forced;

    always_comb
    begin
        nxt_active_setpoint = active_setpoint_ff;
        nxt_active_range = active_range_ff;
        nxt_converter_on = converter_on_ff;
        nxt_pfm_forced = pfm_forced_ff;
        if (clk_en)
        begin
            nxt_active_range = sel.range_sel;
            case (sel.pwr_state)
                PWR_NORMAL:
                begin
                    nxt_active_setpoint = sel.setpoint[IDX_NORMAL];
                    nxt_converter_on = 1'b1;
                    nxt_pfm_forced = 1'b0;
                end
                PWR_STANDBY:
                begin
                    nxt_active_setpoint = sel.setpoint[IDX_STANDBY];
                    nxt_converter_on = 1'b1;
                    nxt_pfm_forced = 1'b0;
                end
                PWR_SLEEP:
                begin
                    nxt_active_setpoint = sel.setpoint[IDX_SLEEP];
                    nxt_converter_on = (sel.sleep_behaviour_sel == SLEEP_BEH_PFM);
                    nxt_pfm_forced = (sel.sleep_behaviour_sel == SLEEP_BEH_PFM);
                end
                default:
                begin
                    nxt_active_setpoint = sel.setpoint[IDX_NORMAL];
                    nxt_converter_on = 1'b1;
                    nxt_pfm_forced = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            active_setpoint_ff <= SETPOINT_RST;
            active_range_ff <= RANGE_RST;
            converter_on_ff <= 1'b0;
            pfm_forced_ff <= 1'b0;
        end
        else
        begin
            active_setpoint_ff <= nxt_active_setpoint;
            active_range_ff <= nxt_active_range;
            converter_on_ff <= nxt_converter_on;
            pfm_forced_ff <= nxt_pfm_forced;
        end
    end

    assign sel.active_setpoint = active_setpoint_ff;
    assign sel.active_range = active_range_ff;
    assign sel.converter_on = converter_on_ff;
    assign sel.pfm_forced = pfm_forced_ff;
endmodule // setpoint_selector

// ### design/buck_b_config_registers.sv
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
module buck_b_config_registers (
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // Register port
    input wire logic [buck_b_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [buck_b_pkg::DATA_W-1:0] reg_wr_data,
    input wire logic reg_wr_strobe,
    input wire logic reg_rd_strobe,
    output logic [buck_b_pkg::DATA_W-1:0] reg_rd_data,
    // One-time memory or test configuration load
    input wire logic cfg_load,
    input wire logic cfg_range,
    // Operating mode requests from power control
    input wire logic standby_req,
    input wire logic sleep_req,
    // Converter controls
    output logic [buck_b_pkg::SETPOINT_W-1:0] regulator_setpoint,
    output logic regulator_range,
    output logic regulator_enable,
    output logic regulator_pfm_forced,
    output buck_b_pkg::pwr_state_t regulator_state,
    output logic [buck_b_pkg::MODE_W-1:0] switching_mode_sel,
    output logic sleep_behaviour_sel,
    output logic current_limit_sel,
    output logic [buck_b_pkg::SEL2_W-1:0] switch_freq_sel,
    output logic [buck_b_pkg::SEL2_W-1:0] phase_clock_sel,
    output logic [buck_b_pkg::SEL2_W-1:0] voltage_ramp_speed
);
    import buck_b_pkg::*;

    // Set points: normal, standby, sleep
    logic [SETPOINT_W-1:0] setpoint_ff [SETPOINT_CNT];
    logic [SETPOINT_W-1:0] nxt_setpoint [SETPOINT_CNT];
    logic [SETPOINT_CNT-1:0] setpoint_wr;

    // Range bit, shared by all three voltage registers
    logic range_ff;
    logic nxt_range;

    // Mode register fields
    logic [MODE_W-1:0] mode_ff;
    logic [MODE_W-1:0] nxt_mode;
    logic sleep_beh_ff;
    logic nxt_sleep_beh;

    // Config register fields
    logic ilim_ff;
    logic nxt_ilim;
    logic [SEL2_W-1:0] freq_ff;
    logic [SEL2_W-1:0] nxt_freq;
    logic [SEL2_W-1:0] phase_ff;
    logic [SEL2_W-1:0] nxt_phase;
    logic [SEL2_W-1:0] speed_ff;
    logic [SEL2_W-1:0] nxt_speed;

    // Operating mode
    pwr_state_t pwr_state_ff;
    pwr_state_t nxt_pwr_state;

    // Read path
    logic [DATA_W-1:0] rd_data_ff;
    logic [DATA_W-1:0] nxt_rd_data;
    logic [DATA_W-1:0] rd_mux;

    // Address decode
    logic wr_mode;
    logic wr_conf;
    logic wr_go;

    // Writes are lost while the clock enable is low
    assign wr_go = clk_en && reg_wr_strobe;
    assign wr_mode = wr_go && (reg_addr == SWITCHING_MODE_OFS);
    assign wr_conf = wr_go && (reg_addr == CONVERTER_CONFIG_OFS);

    // Set point registers, one per operating mode
    generate
        for (genvar i = 0; i < SETPOINT_CNT; i++)
        begin : g_setpoint
            localparam logic [7:0] OFS = NORMAL_VOLTAGE_OFS + 8'(i);

            assign setpoint_wr[i] = wr_go && (reg_addr == OFS);

            always_comb
            begin
                nxt_setpoint[i] = setpoint_ff[i];
                if (setpoint_wr[i])
                begin
                    // Only the low six bits take the write
                    nxt_setpoint[i] = reg_wr_data[SETPOINT_LSB +: SETPOINT_W];
                end
            end

            always_ff @(posedge sys_clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    setpoint_ff[i] <= SETPOINT_RST;
                end
                else
                begin
                    setpoint_ff[i] <= nxt_setpoint[i];
                end
            end
        end
    endgenerate

    // Range bit: software writes never reach it
    always_comb
    begin
        nxt_range = range_ff;
        if (clk_en && cfg_load)
        begin
            nxt_range = cfg_range;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            range_ff <= RANGE_RST;
        end
        else
        begin
            range_ff <= nxt_range;
        end
    end

    // Mode register
    always_comb
    begin
        nxt_mode = mode_ff;
        nxt_sleep_beh = sleep_beh_ff;
        if (wr_mode)
        begin
            nxt_mode = reg_wr_data[MODE_LSB +: MODE_W];
            nxt_sleep_beh = reg_wr_data[SLEEP_BEH_BIT];
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mode_ff <= MODE_RST;
            sleep_beh_ff <= SLEEP_BEH_RST;
        end
        else
        begin
            mode_ff <= nxt_mode;
            sleep_beh_ff <= nxt_sleep_beh;
        end
    end

    // Config register; bit one is not stored
    always_comb
    begin
        nxt_ilim = ilim_ff;
        nxt_freq = freq_ff;
        nxt_phase = phase_ff;
        nxt_speed = speed_ff;
        if (wr_conf)
        begin
            nxt_ilim = reg_wr_data[ILIM_BIT];
            nxt_freq = reg_wr_data[FREQ_LSB +: SEL2_W];
            nxt_phase = reg_wr_data[PHASE_LSB +: SEL2_W];
            nxt_speed = reg_wr_data[SPEED_LSB +: SEL2_W];
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ilim_ff <= ILIM_RST;
            freq_ff <= SEL2_RST;
            phase_ff <= SEL2_RST;
            speed_ff <= SEL2_RST;
        end
        else
        begin
            ilim_ff <= nxt_ilim;
            freq_ff <= nxt_freq;
            phase_ff <= nxt_phase;
            speed_ff <= nxt_speed;
        end
    end

    // Operating mode tracking; sleep outranks standby
    // Sleep is entered and left through standby, one step per edge
    always_comb
    begin
        nxt_pwr_state = pwr_state_ff;
        if (clk_en)
        begin
            case (pwr_state_ff)
                PWR_NORMAL:
                begin
                    if (sleep_req || standby_req)
                    begin
                        nxt_pwr_state = PWR_STANDBY;
                    end
                end
                PWR_STANDBY:
                begin
                    if (sleep_req)
                    begin
                        nxt_pwr_state = PWR_SLEEP;
                    end
                    else if (!standby_req)
                    begin
                        nxt_pwr_state = PWR_NORMAL;
                    end
                end
                PWR_SLEEP:
                begin
                    if (!sleep_req)
                    begin
                        nxt_pwr_state = PWR_STANDBY;
                    end
                end
                default:
                begin
                    nxt_pwr_state = PWR_NORMAL;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pwr_state_ff <= PWR_NORMAL;
        end
        else
        begin
            pwr_state_ff <= nxt_pwr_state;
        end
    end

    // Read mux; unmapped addresses and unused bits give zero
    always_comb
    begin
        rd_mux = '0;
        case (reg_addr)
            NORMAL_VOLTAGE_OFS:
            begin
                rd_mux[SETPOINT_LSB +: SETPOINT_W] = setpoint_ff[IDX_NORMAL];
                rd_mux[RANGE_BIT] = range_ff;
            end
            STANDBY_VOLTAGE_OFS:
            begin
                rd_mux[SETPOINT_LSB +: SETPOINT_W] = setpoint_ff[IDX_STANDBY];
                rd_mux[RANGE_BIT] = range_ff;
            end
            SLEEP_VOLTAGE_OFS:
            begin
                rd_mux[SETPOINT_LSB +: SETPOINT_W] = setpoint_ff[IDX_SLEEP];
                rd_mux[RANGE_BIT] = range_ff;
            end
            SWITCHING_MODE_OFS:
            begin
                rd_mux[MODE_LSB +: MODE_W] = mode_ff;
                rd_mux[SLEEP_BEH_BIT] = sleep_beh_ff;
            end
            CONVERTER_CONFIG_OFS:
            begin
                rd_mux[ILIM_BIT] = ilim_ff;
                rd_mux[FREQ_LSB +: SEL2_W] = freq_ff;
                rd_mux[PHASE_LSB +: SEL2_W] = phase_ff;
                rd_mux[SPEED_LSB +: SEL2_W] = speed_ff;
            end
            default:
            begin
                rd_mux = '0;
            end
        endcase
    end

    // Read data stands until the next edge with the clock enable high
    // Zero outside that cycle so idle bus reads nothing stale
    always_comb
    begin
        nxt_rd_data = rd_data_ff;
        if (clk_en)
        begin
            nxt_rd_data = reg_rd_strobe ? rd_mux : RD_DATA_RST;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rd_data_ff <= RD_DATA_RST;
        end
        else
        begin
            rd_data_ff <= nxt_rd_data;
        end
    end

    assign reg_rd_data = rd_data_ff;

    // Active set point selection
    setpoint_sel_if sel_bus ();

    generate
        for (genvar j = 0; j < SETPOINT_CNT; j++)
        begin : g_sel_bus
            assign sel_bus.setpoint[j] = setpoint_ff[j];
        end
    endgenerate

    assign sel_bus.range_sel = range_ff;
    assign sel_bus.sleep_behaviour_sel = sleep_beh_ff;
    assign sel_bus.pwr_state = pwr_state_ff;

    setpoint_selector u_selector (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .sel(sel_bus.selector)
    );

    // Converter controls
    assign regulator_setpoint = sel_bus.active_setpoint;
    assign regulator_range = sel_bus.active_range;
    assign regulator_enable = sel_bus.converter_on;
    assign regulator_pfm_forced = sel_bus.pfm_forced;
    assign regulator_state = pwr_state_ff;
    assign switching_mode_sel = mode_ff;
    assign sleep_behaviour_sel = sleep_beh_ff;
    assign current_limit_sel = ilim_ff;
    assign switch_freq_sel = freq_ff;
    assign phase_clock_sel = phase_ff;
    assign voltage_ramp_speed = speed_ff;
endmodule // buck_b_config_registers

// ### testbench/buck_b_config_registers_checker.sv
`timescale 1ns/1ps
module buck_b_config_registers_checker (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // Register port
    input wire logic [buck_b_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [buck_b_pkg::DATA_W-1:0] reg_wr_data,
    input wire logic reg_wr_strobe,
    input wire logic reg_rd_strobe,
    input wire logic [buck_b_pkg::DATA_W-1:0] reg_rd_data,
    // Configuration load
    input wire logic cfg_load,
    input wire logic cfg_range,
    // Converter side
    input wire logic regulator_range,
    input wire logic regulator_enable,
    input wire logic regulator_pfm_forced,
    input wire buck_b_pkg::pwr_state_t regulator_state,
    input wire logic [buck_b_pkg::MODE_W-1:0] switching_mode_sel,
    input wire logic sleep_behaviour_sel,
    input wire logic current_limit_sel,
    input wire logic [buck_b_pkg::SEL2_W-1:0] switch_freq_sel,
    input wire logic [buck_b_pkg::SEL2_W-1:0] phase_clock_sel,
    input wire logic [buck_b_pkg::SEL2_W-1:0] voltage_ramp_speed
);
    import buck_b_pkg::*;
    logic [7:0] wd_q;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // Write data of the previous edge
    always_ff @(posedge sys_clk)
    begin
        wd_q <= reg_wr_data;
    end
    a_mode_write: assert property (
        reg_wr_strobe && clk_en && reg_addr == SWITCHING_MODE_OFS |=>
        switching_mode_sel == wd_q[3:0] && sleep_behaviour_sel == wd_q[5])
        else $error("mode write not applied");
    a_cfg_low_write: assert property (
        reg_wr_strobe && clk_en && reg_addr == CONVERTER_CONFIG_OFS |=>
        current_limit_sel == wd_q[0] && switch_freq_sel == wd_q[3:2])
        else $error("limit or frequency write not applied");
    a_cfg_high_write: assert property (
        reg_wr_strobe && clk_en && reg_addr == CONVERTER_CONFIG_OFS |=>
        phase_clock_sel == wd_q[5:4] && voltage_ramp_speed == wd_q[7:6])
        else $error("phase or speed write not applied");
    a_range_read_mirror: assert property (
        reg_rd_strobe && clk_en && reg_addr inside {[8'h43:8'h45]} |=>
        reg_rd_data[7:6] == {1'b0, regulator_range})
        else $error("range bit read wrong");
    a_mode_read_unused: assert property (
        reg_rd_strobe && clk_en && reg_addr == SWITCHING_MODE_OFS |=>
        reg_rd_data[7:6] == 2'b00 && !reg_rd_data[4] && reg_rd_data[3:0] == switching_mode_sel)
        else $error("mode read wrong");
    a_read_idle_zero: assert property (
        !reg_rd_strobe && clk_en |=> reg_rd_data == 8'h00)
        else $error("read data not zero when idle");
    a_range_load: assert property (
        cfg_load && clk_en ##1 clk_en |=> regulator_range == $past(cfg_range, 2))
        else $error("range load not followed");
    a_sleep_drive: assert property (
        clk_en && regulator_state == PWR_SLEEP |=>
        regulator_enable == $past(sleep_behaviour_sel)
        && regulator_pfm_forced == $past(sleep_behaviour_sel))
        else $error("sleep behaviour not applied");
    a_awake_running: assert property (
        reset_n && clk_en && regulator_state != PWR_SLEEP |=>
        regulator_enable && !regulator_pfm_forced)
        else $error("converter not running awake");
endmodule // buck_b_config_registers_checker

// ### testbench/buck_b_config_registers_tb.sv
`timescale 1ns/1ps
module buck_b_config_registers_tb;
    import buck_b_pkg::*;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic clk_en = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wr_data = 8'h00;
    logic reg_wr_strobe = 1'b0;
    logic reg_rd_strobe = 1'b0;
    logic [7:0] reg_rd_data;
    logic cfg_load = 1'b0;
    logic cfg_range = 1'b0;
    logic standby_req = 1'b0;
    logic sleep_req = 1'b0;
    logic [5:0] reg_sp;
    logic reg_range;
    logic reg_en;
    logic reg_pfm;
    pwr_state_t reg_state;
    logic [3:0] mode_sel;
    logic beh_sel;
    logic ilim_sel;
    logic [1:0] freq_sel;
    logic [1:0] phase_sel;
    logic [1:0] speed_sel;
    int error_cnt = 0;
    int num_checks = 0;
    logic [7:0] rst_tbl [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h00, 8'h00};
    logic [7:0] ones_tbl [6] = '{8'h3F, 8'h3F, 8'h3F, 8'h2F, 8'hFD, 8'h00};

    always #25 sys_clk = ~sys_clk;

    buck_b_config_registers dut (
        .sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_wr_strobe(reg_wr_strobe),
        .reg_rd_strobe(reg_rd_strobe), .reg_rd_data(reg_rd_data),
        .cfg_load(cfg_load), .cfg_range(cfg_range),
        .standby_req(standby_req), .sleep_req(sleep_req),
        .regulator_setpoint(reg_sp), .regulator_range(reg_range),
        .regulator_enable(reg_en), .regulator_pfm_forced(reg_pfm),
        .regulator_state(reg_state), .switching_mode_sel(mode_sel),
        .sleep_behaviour_sel(beh_sel), .current_limit_sel(ilim_sel),
        .switch_freq_sel(freq_sel), .phase_clock_sel(phase_sel),
        .voltage_ramp_speed(speed_sel)
    );

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_rd_strobe <= 1'b0;
        reg_wr_strobe <= 1'b1;
        reg_addr <= a;
        reg_wr_data <= d;
    endtask

    task automatic idle();
        @(posedge sys_clk);
        reg_wr_strobe <= 1'b0;
        reg_rd_strobe <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_wr_strobe <= 1'b0;
        reg_rd_strobe <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd_strobe <= 1'b0;
        @(negedge sys_clk);
        check($sformatf("reg %h", a), exp, reg_rd_data);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Guard against a hang
    initial
    begin
        #2000000;
        error_cnt++;
        results();
    end

    initial
    begin
        repeat (6) @(posedge sys_clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 7; i++)
            rd(8'h42 + 8'(i), rst_tbl[i]);
        check("mode out", 8'h08, 8'(mode_sel));
        check("enable", 8'h01, 8'(reg_en));
        $display("test reset_values done");
        // All ones, unused and read-only bits must drop
        for (int i = 0; i < 6; i++)
            wr(8'h43 + 8'(i), 8'hFF);
        idle();
        settle(0);
        check("mode out", 8'h0F, 8'(mode_sel));
        check("behaviour", 8'h01, 8'(beh_sel));
        check("limit", 8'h01, 8'(ilim_sel));
        check("freq", 8'h03, 8'(freq_sel));
        check("phase", 8'h03, 8'(phase_sel));
        check("speed", 8'h03, 8'(speed_sel));
        for (int i = 0; i < 6; i++)
            rd(8'h43 + 8'(i), ones_tbl[i]);
        wr(8'h47, 8'h9C);
        wr(8'h46, 8'h25);
        idle();
        settle(0);
        check("limit", 8'h00, 8'(ilim_sel));
        check("freq", 8'h03, 8'(freq_sel));
        check("phase", 8'h01, 8'(phase_sel));
        check("speed", 8'h02, 8'(speed_sel));
        check("mode out", 8'h05, 8'(mode_sel));
        rd(8'h47, 8'h9C);
        rd(8'h46, 8'h25);
        $display("test field_map done");
        // Write while frozen is lost
        @(posedge sys_clk);
        clk_en <= 1'b0;
        wr(8'h44, 8'h3A);
        idle();
        clk_en <= 1'b1;
        rd(8'h44, 8'h3F);
        $display("test freeze done");
        // Range load, then a write trying to clear it
        @(posedge sys_clk);
        cfg_load <= 1'b1;
        cfg_range <= 1'b1;
        @(posedge sys_clk);
        cfg_load <= 1'b0;
        wr(8'h43, 8'h00);
        rd(8'h43, 8'h40);
        rd(8'h44, 8'h7F);
        rd(8'h45, 8'h7F);
        check("range out", 8'h01, 8'(reg_range));
        $display("test range done");
        // Mode walk through the set points
        wr(8'h43, 8'h11);
        wr(8'h44, 8'h22);
        wr(8'h45, 8'h33);
        wr(8'h46, 8'h28);
        idle();
        sleep_req <= 1'b1;
        settle(4);
        check("state", 8'(PWR_SLEEP), 8'(reg_state));
        check("setpoint", 8'h33, 8'(reg_sp));
        check("enable", 8'h01, 8'(reg_en));
        check("pfm", 8'h01, 8'(reg_pfm));
        wr(8'h46, 8'h08);
        idle();
        settle(2);
        check("enable", 8'h00, 8'(reg_en));
        check("pfm", 8'h00, 8'(reg_pfm));
        @(posedge sys_clk);
        sleep_req <= 1'b0;
        standby_req <= 1'b1;
        settle(4);
        check("state", 8'(PWR_STANDBY), 8'(reg_state));
        check("setpoint", 8'h22, 8'(reg_sp));
        check("enable", 8'h01, 8'(reg_en));
        @(posedge sys_clk);
        standby_req <= 1'b0;
        settle(4);
        check("state", 8'(PWR_NORMAL), 8'(reg_state));
        check("setpoint", 8'h11, 8'(reg_sp));
        $display("test mode_walk done");
        results();
    end
endmodule // buck_b_config_registers_tb

bind buck_b_config_registers buck_b_config_registers_checker chk_i (
    .sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data), .reg_wr_strobe(reg_wr_strobe),
    .reg_rd_strobe(reg_rd_strobe), .reg_rd_data(reg_rd_data),
    .cfg_load(cfg_load), .cfg_range(cfg_range), .regulator_range(regulator_range),
    .regulator_enable(regulator_enable), .regulator_pfm_forced(regulator_pfm_forced),
    .regulator_state(regulator_state), .switching_mode_sel(switching_mode_sel),
    .sleep_behaviour_sel(sleep_behaviour_sel), .current_limit_sel(current_limit_sel),
    .switch_freq_sel(switch_freq_sel), .phase_clock_sel(phase_clock_sel),
    .voltage_ramp_speed(voltage_ramp_speed)
);
